// ==== tupcg_pkg.sv ====
package tupcg_pkg;
	localparam int unsigned ADDR_W = 20;
	localparam int unsigned CNT_W  = 15;
	localparam int unsigned NUM_CH = 8;

	// register offsets
	localparam logic [19:0] PERIPHERAL_CLOCK_GATE_OFS  = 20'hf00f0;
	localparam logic [19:0] TIMER_PRESCALER_SELECT_OFS = 20'hf01b6;

	// reset values
	localparam logic [7:0]  PERIPHERAL_CLOCK_GATE_RST  = 8'h00;
	localparam logic [15:0] TIMER_PRESCALER_SELECT_RST = 16'h0000;

	// implemented bits; bits 3 and 1 of the gate register and
	// bits 15, 14, 11, 10 of the prescaler select read as zero
	localparam logic [7:0]  PERIPHERAL_CLOCK_GATE_MASK  = 8'hf5;
	localparam logic [15:0] TIMER_PRESCALER_SELECT_MASK = 16'h33ff;

	// field positions
	localparam int unsigned TIMER_UNIT_CLOCK_GATE_BIT = 0;
	localparam int unsigned CLK0_FIELD_LSB = 0;
	localparam int unsigned CLK1_FIELD_LSB = 4;
	localparam int unsigned CLK2_FIELD_LSB = 8;
	localparam int unsigned CLK3_FIELD_LSB = 12;

	// channel operation clock pick codes
	localparam logic [1:0] PICK_CLK0 = 2'h0;
	localparam logic [1:0] PICK_CLK2 = 2'h1;
	localparam logic [1:0] PICK_CLK1 = 2'h2;
	localparam logic [1:0] PICK_CLK3 = 2'h3;

	// divide exponents for the 2-bit selectors, indexed by code
	localparam logic [3:0] CLK2_EXP0 = 4'h1;
	localparam logic [3:0] CLK2_EXP1 = 4'h2;
	localparam logic [3:0] CLK2_EXP2 = 4'h4;
	localparam logic [3:0] CLK2_EXP3 = 4'h6;
	localparam logic [3:0] CLK3_EXP0 = 4'h8;
	localparam logic [3:0] CLK3_EXP1 = 4'ha;
	localparam logic [3:0] CLK3_EXP2 = 4'hc;
	localparam logic [3:0] CLK3_EXP3 = 4'he;

	// channels allowed to use shared clocks two and three
	localparam logic [7:0] WIDE_PICK_CHANNELS = 8'h0a;
endpackage

// ==== tupcg_top.sv ====
`timescale 1ns/1ps
// Overview of operation
// - gate low: clock stopped, unit reset, prescaler select writes ignored
// - gate high: clock supplied, registers read/write
// - gate low clears prescaler, blocks its writes
// - clocks zero/one from prescaler bits 3:0, 7:4
// - clocks two/three from bits 9:8, 13:12
// - two-bit codes map to fixed division sets
// - divided clocks are one-cycle pulses, except divide-by-1 on clocks zero/one, which stays high
// - system reset clears prescaler select to zero
// - channel pick codes select shared clocks
module tupcg_top
	import tupcg_pkg::*;
(
	input  wire logic              core_clk,                // system clock, 200 MHz
	input  wire logic              rst,                     // async reset, active high
	input  wire logic              reg_wr,                  // register write strobe
	input  wire logic [ADDR_W-1:0] reg_wr_addr,             // write address
	input  wire logic [15:0]       reg_wr_data,             // write data
	input  wire logic              reg_rd,                  // register read strobe
	input  wire logic [ADDR_W-1:0] reg_rd_addr,             // read address
	input  wire logic [2*NUM_CH-1:0] channel_clock_pick,    // per channel {high,low} pick
	output logic [15:0]            reg_rd_data,             // read data, one cycle after strobe
	output logic                   timer_unit_gate_flag,    // unit input clock supplied
	output logic                   timer_unit_reset,        // unit held in reset
	output logic                   shared_clock_zero,       // operation clock pulse 0
	output logic                   shared_clock_one,        // operation clock pulse 1
	output logic                   shared_clock_two,        // operation clock pulse 2
	output logic                   shared_clock_three,      // operation clock pulse 3
	output logic [NUM_CH-1:0]      channel_operation_clock  // selected pulse per channel
);

	logic [7:0]       peripheral_clock_gate;
	logic [15:0]      timer_prescaler_select;
	logic [CNT_W-1:0] prescale_count;
	logic [3:0]       shared_pulse;
	logic [7:0]       next_peripheral_clock_gate;
	logic [15:0]      next_timer_prescaler_select;
	logic [CNT_W-1:0] next_prescale_count;
	logic [3:0]       next_shared_pulse;
	logic [15:0]      next_reg_rd_data;
	logic             gate;
	logic             wr_gate_hit;
	logic             wr_sel_hit;
	logic             rd_gate_hit;
	logic             rd_sel_hit;

	// low k bits of the counter all ones marks the end of a 2^k interval
	function automatic logic interval_end(input logic [CNT_W-1:0] cnt,
		input logic [3:0] k);
		logic [CNT_W-1:0] m;
		m = CNT_W'((32'h1 << k) - 32'h1);
		return (cnt & m) == m;
	endfunction

	function automatic logic [3:0] clk2_exp(input logic [1:0] code);
		logic [3:0] e;
		e = CLK2_EXP0;
		unique case (code)
			2'h0: e = CLK2_EXP0;
			2'h1: e = CLK2_EXP1;
			2'h2: e = CLK2_EXP2;
			2'h3: e = CLK2_EXP3;
		endcase
		return e;
	endfunction

	function automatic logic [3:0] clk3_exp(input logic [1:0] code);
		logic [3:0] e;
		e = CLK3_EXP0;
		unique case (code)
			2'h0: e = CLK3_EXP0;
			2'h1: e = CLK3_EXP1;
			2'h2: e = CLK3_EXP2;
			2'h3: e = CLK3_EXP3;
		endcase
		return e;
	endfunction

	// full-address match; a partial decode would alias other peripherals
	function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs);
		return addr == ofs;
	endfunction

	function automatic logic pick_pulse(input logic [1:0] pick,
		input logic [3:0] pulse,
		input logic       wide);
		logic p;
		p = 1'b0;
		unique case (pick)
			PICK_CLK0: p = pulse[0];
			PICK_CLK1: p = pulse[1];
			// clocks two and three only where wired
			PICK_CLK2: p = wide & pulse[2];
			PICK_CLK3: p = wide & pulse[3];
		endcase
		return p;
	endfunction

	// gate bit doubles as synchronous reset of the whole unit;
	// it is a register bit of this clock, so no synchroniser
	assign gate = peripheral_clock_gate[TIMER_UNIT_CLOCK_GATE_BIT];

	// decoded register strobes
	assign wr_gate_hit = reg_wr && addr_hit(reg_wr_addr, PERIPHERAL_CLOCK_GATE_OFS);
	assign wr_sel_hit  = reg_wr && addr_hit(reg_wr_addr, TIMER_PRESCALER_SELECT_OFS);
	assign rd_gate_hit = reg_rd && addr_hit(reg_rd_addr, PERIPHERAL_CLOCK_GATE_OFS);
	assign rd_sel_hit  = reg_rd && addr_hit(reg_rd_addr, TIMER_PRESCALER_SELECT_OFS);

	assign timer_unit_reset = ~gate;
	assign timer_unit_gate_flag = gate;

	// register file; writes to unmapped addresses fall through unchanged
	always_comb begin
		next_peripheral_clock_gate  = peripheral_clock_gate;
		next_timer_prescaler_select = timer_prescaler_select;
		next_reg_rd_data            = reg_rd_data;
		if (wr_gate_hit) begin
			// gate register itself is outside the unit, always writable;
			// bits 3 and 1 are not stored
			next_peripheral_clock_gate = reg_wr_data[7:0] & PERIPHERAL_CLOCK_GATE_MASK;
		end
		// cleared and write-locked while gated off
		if (!gate) begin
			next_timer_prescaler_select = TIMER_PRESCALER_SELECT_RST;
		end else if (wr_sel_hit) begin
			// whole word taken, unused bits dropped
			next_timer_prescaler_select = reg_wr_data & TIMER_PRESCALER_SELECT_MASK;
		end
		// read data holds until the next read strobe
		if (reg_rd) begin
			if (rd_gate_hit)
				next_reg_rd_data = {8'h00, peripheral_clock_gate};
			// zero while gated, also before the clear has landed
			else if (rd_sel_hit)
				next_reg_rd_data = gate ? timer_prescaler_select : 16'h0000;
			else
				next_reg_rd_data = 16'h0000;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			peripheral_clock_gate  <= PERIPHERAL_CLOCK_GATE_RST;
			timer_prescaler_select <= TIMER_PRESCALER_SELECT_RST;
			reg_rd_data            <= 16'h0000;
		end else begin
			peripheral_clock_gate  <= next_peripheral_clock_gate;
			timer_prescaler_select <= next_timer_prescaler_select;
			reg_rd_data            <= next_reg_rd_data;
		end
	end

	// prescaler counter and pulse generation; 15 bits reach exponent 15.
	// limitation: a selector change mid-run can give one short interval,
	// since all pulses share the counter's phase
	always_comb begin
		// one counter, runs only while gated on
		next_prescale_count = gate ? prescale_count + CNT_W'(1) : '0;
		next_shared_pulse[0] = gate && interval_end(prescale_count,
			timer_prescaler_select[CLK0_FIELD_LSB +: 4]);
		next_shared_pulse[1] = gate && interval_end(prescale_count,
			timer_prescaler_select[CLK1_FIELD_LSB +: 4]);
		next_shared_pulse[2] = gate && interval_end(prescale_count,
			clk2_exp(timer_prescaler_select[CLK2_FIELD_LSB +: 2]));
		next_shared_pulse[3] = gate && interval_end(prescale_count,
			clk3_exp(timer_prescaler_select[CLK3_FIELD_LSB +: 2]));
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prescale_count <= '0;
			shared_pulse   <= 4'h0;
		end else begin
			prescale_count <= next_prescale_count;
			shared_pulse   <= next_shared_pulse;
		end
	end

	// registered pulses keep glitches off the channel muxes
	assign shared_clock_zero  = shared_pulse[0];
	assign shared_clock_one   = shared_pulse[1];
	assign shared_clock_two   = shared_pulse[2];
	assign shared_clock_three = shared_pulse[3];

	// per-channel operation clock; picks come from same-clock logic,
	// and the mux stays combinational since its inputs are all flops
	for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_chan
		logic [1:0] pick;
		assign pick = channel_clock_pick[2*ch +: 2];
		assign channel_operation_clock[ch] = pick_pulse(pick, shared_pulse,
			WIDE_PICK_CHANNELS[ch]);
	end

endmodule

// ==== tupcg_assertions.sv ====
`timescale 1ns/1ps
module tupcg_assertions
	import tupcg_pkg::*;
(
	input wire logic                core_clk,                // clock
	input wire logic                rst,                     // reset
	input wire logic                reg_wr,                  // write
	input wire logic [ADDR_W-1:0]   reg_wr_addr,             // waddr
	input wire logic [15:0]         reg_wr_data,             // wdata
	input wire logic                reg_rd,                  // read
	input wire logic [ADDR_W-1:0]   reg_rd_addr,             // raddr
	input wire logic [2*NUM_CH-1:0] channel_clock_pick,      // picks
	input wire logic [15:0]         reg_rd_data,             // rdata
	input wire logic                timer_unit_gate_flag,    // gate
	input wire logic                timer_unit_reset,        // unit reset
	input wire logic                shared_clock_zero,       // pulse 0
	input wire logic                shared_clock_one,        // pulse 1
	input wire logic                shared_clock_two,        // pulse 2
	input wire logic                shared_clock_three,      // pulse 3
	input wire logic [NUM_CH-1:0]   channel_operation_clock  // per channel
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// clock three stays quiet for at least 8 cycles after each pulse
	sequence s_quiet; !shared_clock_three [*8]; endsequence
	property p_gate_off; !timer_unit_gate_flag [*2] |-> !(shared_clock_zero |
		shared_clock_one | shared_clock_two | shared_clock_three); endproperty
	property p_reset; timer_unit_reset != timer_unit_gate_flag; endproperty
	property p_gate_wr; reg_wr && reg_wr_addr == PERIPHERAL_CLOCK_GATE_OFS
		|=> timer_unit_gate_flag == $past(reg_wr_data[0]); endproperty
	property p_sel_gated; reg_rd && reg_rd_addr == TIMER_PRESCALER_SELECT_OFS &&
		!timer_unit_gate_flag |=> reg_rd_data == 16'h0000; endproperty
	property p_two; shared_clock_two |=> !shared_clock_two; endproperty
	property p_three; shared_clock_three |=> s_quiet; endproperty
	property p_ch0; channel_operation_clock[0] == (channel_clock_pick[1:0] == PICK_CLK0 ?
		shared_clock_zero : channel_clock_pick[1:0] == PICK_CLK1 ? shared_clock_one : 1'b0);
	endproperty
	property p_ch1; channel_clock_pick[3:2] == PICK_CLK2 |->
		channel_operation_clock[1] == shared_clock_two; endproperty
	property p_unmapped; reg_rd && reg_rd_addr == 20'h00000 |=> reg_rd_data == 16'h0000;
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("pulse while gated");
	a_reset: assert property (p_reset) else $error("unit reset mismatch");
	a_gate_wr: assert property (p_gate_wr) else $error("gate flag wrong");
	a_sel_gated: assert property (p_sel_gated) else $error("select not cleared");
	a_two: assert property (p_two) else $error("pulse too long");
	a_three: assert property (p_three) else $error("clock three too fast");
	a_ch0: assert property (p_ch0) else $error("channel 0 mux wrong");
	a_ch1: assert property (p_ch1) else $error("channel 1 mux wrong");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule
bind tupcg_top tupcg_assertions u_chk (.core_clk, .rst, .reg_wr, .reg_wr_addr,
	.reg_wr_data, .reg_rd, .reg_rd_addr, .channel_clock_pick, .reg_rd_data,
	.timer_unit_gate_flag, .timer_unit_reset, .shared_clock_zero, .shared_clock_one,
	.shared_clock_two, .shared_clock_three, .channel_operation_clock);

// ==== tupcg_bench.sv ====
`timescale 1ns/1ps
module tupcg_bench import tupcg_pkg::*;;
	typedef struct {logic [15:0] sel; int idx; int per;} tupcg_row_s;
	logic              core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
	logic [ADDR_W-1:0] reg_wr_addr = '0, reg_rd_addr = '0;
	logic [15:0]       reg_wr_data = '0, channel_clock_pick = 16'he4e4;
	wire logic [15:0]  reg_rd_data;
	wire logic         gate, unit_rst;
	wire logic [3:0]   pulses;
	wire logic [7:0]   chan_clk;
	int                num_errors = 0, total_checks = 0, n;
	tupcg_row_s rows [11] = '{'{16'h0000, 0, 1}, '{16'h0003, 0, 8}, '{16'h0050, 1, 32},
		'{16'h0000, 2, 2}, '{16'h0100, 2, 4}, '{16'h0200, 2, 16}, '{16'h0300, 2, 64},
		'{16'h0000, 3, 256}, '{16'h1000, 3, 1024}, '{16'h2000, 3, 4096},
		'{16'h3000, 3, 16384}};
	always #2.5 core_clk = ~core_clk;
	tupcg_top DUT (.core_clk, .rst, .reg_wr, .reg_wr_addr, .reg_wr_data, .reg_rd,
		.reg_rd_addr, .channel_clock_pick, .reg_rd_data, .timer_unit_gate_flag(gate),
		.timer_unit_reset(unit_rst), .shared_clock_zero(pulses[0]),
		.shared_clock_one(pulses[1]), .shared_clock_two(pulses[2]),
		.shared_clock_three(pulses[3]), .channel_operation_clock(chan_clk));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [19:0] a, input logic [15:0] d);
		@(posedge core_clk) #1 {reg_wr, reg_wr_addr, reg_wr_data} = {1'b1, a, d};
		@(posedge core_clk) #1 reg_wr = 0;
	endtask
	task rd(input logic [19:0] a, input logic [15:0] exp);
		@(posedge core_clk) #1 {reg_rd, reg_rd_addr} = {1'b1, a};
		@(posedge core_clk) #1 reg_rd = 0;
		chk(reg_rd_data, exp);
	endtask
	// cycles between two pulses, bounded
	task meas(input int i, output int c);
		c = 0;
		while (pulses[i] !== 1'b1 && c < 40000) begin
			@(negedge core_clk);
			c++;
		end
		c = 0;
		do begin
			@(negedge core_clk);
			c++;
		end while (pulses[i] !== 1'b1 && c < 40000);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#300000 num_errors++;
		give_verdict();
	end
	initial begin
		repeat (8) @(posedge core_clk);
		#1 rst = 0;
		chk(16'({gate, unit_rst}), 16'h0001);
		rd(PERIPHERAL_CLOCK_GATE_OFS, 16'h0000);
		wr(TIMER_PRESCALER_SELECT_OFS, 16'h0123);
		rd(TIMER_PRESCALER_SELECT_OFS, 16'h0000);
		wr(PERIPHERAL_CLOCK_GATE_OFS, 16'h00bd);
		rd(PERIPHERAL_CLOCK_GATE_OFS, {8'h00, 8'hbd & PERIPHERAL_CLOCK_GATE_MASK});
		chk(16'({gate, unit_rst}), 16'h0002);
		wr(TIMER_PRESCALER_SELECT_OFS, 16'h33ff);
		rd(TIMER_PRESCALER_SELECT_OFS, 16'h33ff);
		rd(20'h00000, 16'h0000);
		$display("register test done");
		// system clock never changes; no compare values used
		foreach (rows[r]) begin
			wr(TIMER_PRESCALER_SELECT_OFS, rows[r].sel); // no channel runs
			repeat (3) @(negedge core_clk);
			meas(rows[r].idx, n);
			chk(16'(n), 16'(rows[r].per));
		end
		// settle on a clock-two pulse with clock three quiet
		@(negedge core_clk);
		while (pulses[2] !== 1'b1 || pulses[3] !== 1'b0) @(negedge core_clk);
		chk(16'(chan_clk), 16'h0057);
		$display("divider test done");
		wr(PERIPHERAL_CLOCK_GATE_OFS, 16'h0000);
		chk(16'({gate, unit_rst}), 16'h0001);
		wr(PERIPHERAL_CLOCK_GATE_OFS, 16'h0001);
		rd(TIMER_PRESCALER_SELECT_OFS, 16'h0000);
		#1 rst = 1;
		@(posedge core_clk) #1 rst = 0;
		rd(PERIPHERAL_CLOCK_GATE_OFS, 16'h0000);
		$display("gate and reset test done");
		give_verdict();
	end
endmodule
